//--- hw/cfr_pkg.sv
`default_nettype none
package cfr_pkg;
	// global register space, byte addresses; bit 11 selects bank space
	localparam logic [11:0] OFF_SCR0   = 12'h000;
	localparam logic [11:0] OFF_SCR1   = 12'h004;
	localparam logic [11:0] OFF_NSCR0  = 12'h008;
	localparam logic [11:0] OFF_SGFSR  = 12'h010;
	localparam logic [11:0] OFF_NSGFSR = 12'h014;
	localparam logic [11:0] OFF_SSYN0  = 12'h018;
	localparam logic [11:0] OFF_SGFAR  = 12'h01C;
	localparam logic [11:0] OFF_NSGFAR = 12'h020;
	localparam logic [11:0] OFF_GPAR   = 12'h024;
	localparam int unsigned BANK_BIT   = 11;
	localparam int unsigned BANK_MSB   = 10;
	localparam int unsigned BANK_LSB   = 8;
	localparam logic [7:0]  BOFF_FSR   = 8'h00;
	localparam logic [7:0]  BOFF_FAR   = 8'h04;
	localparam logic [7:0]  BOFF_PAR   = 8'h08;
	// control0 fields (secure and non-secure copies)
	localparam int unsigned C0_W       = 3;
	localparam int unsigned C0_IRQ     = 0;
	localparam int unsigned C0_REP     = 1;
	localparam int unsigned C0_GIRQ    = 2;
	// secure_control1 fields
	localparam int unsigned C1_W       = 3;
	localparam int unsigned C1_NS_CFG_FAULT_REDIRECT = 0;
	localparam int unsigned C1_GLOBAL_SPACE_SECURE_ONLY  = 1;
	localparam int unsigned C1_EXT_FAULT_SECURE_REDIRECT   = 2;
	// fault status fields
	localparam int unsigned FS_EF      = 0;
	localparam int unsigned FS_CAF     = 1;
	localparam int unsigned FS_MULTI   = 31;
	localparam logic [31:0] FS_MASK    = 32'h80000003;
	localparam logic [31:0] FS_GLB     = 32'h80000001;
	// translation result fields
	localparam logic [31:0] PAR_EXT    = 32'h00000003;
	localparam logic [31:0] PAR_TRANSLATION_OP_TERMINATED   = 32'h00000005;
	// reset values
	localparam logic [31:0] RST_W32    = 32'h00000000;
	localparam logic [2:0]  RST_CTL    = 3'h0;

	typedef enum logic [1:0] {
		CFR_WALK_CLIENT,
		CFR_WALK_ATOS,
		CFR_DOWNSTREAM
	} cfr_src_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
		logic        secure;
		logic        priv;
	} cfr_cfg_req_t;

	typedef struct packed {
		cfr_src_t    src;
		logic        sync;
		logic        bypass;
		logic        nested;
		logic        s2_for_s1_op;
		logic [2:0]  bank;
		logic [2:0]  s2_bank;
		logic        sec_known;
		logic        secure;
		logic [31:0] addr;
	} cfr_ext_fault_t;
endpackage
`default_nettype wire

//--- hw/cfr_core.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cfr_core #(
	parameter int unsigned NB           = 4,
	parameter logic [7:0]  BANK_SECURE  = 8'h00,
	parameter bit          TWO_SEC      = 1'b1,
	parameter bit          UPSTREAM_ERR = 1'b0,
	parameter bit          UNIMPL_CAF   = 1'b1,
	parameter bit          NS_CAF       = 1'b1,
	parameter bit          PRIV_CAF     = 1'b0,
	parameter bit          ASYNC_GLOBAL = 1'b1
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_b_i,
	input  wire cfr_pkg::cfr_cfg_req_t  cfg_req_i,
	input  wire logic                   ext_valid_i,
	input  wire cfr_pkg::cfr_ext_fault_t ext_fault_i,
	output logic [31:0]                 reg_rdata_o,
	output logic                        reg_abort_o,
	output logic                        client_abort_o,
	output logic                        secure_cfg_fault_interrupt_o,
	output logic                        secure_global_interrupt_o,
	output logic                        ns_cfg_fault_interrupt_o,
	output logic                        ns_global_interrupt_o
);
	import cfr_pkg::*;

	generate
		if (NB < 1 || NB > 8) begin : g_bad_nb
			$error("bank count must be 1 to 8");
		end
	endgenerate

	typedef struct packed {
		logic [C0_W-1:0]       s_ctl0;
		logic [C0_W-1:0]       ns_ctl0;
		logic [C1_W-1:0]       s_ctl1;
		logic [31:0]           s_fsr;
		logic [31:0]           ns_fsr;
		logic                  s_syn_ns;
		logic [31:0]           s_far;
		logic [31:0]           ns_far;
		logic [31:0]           gpar;
		logic [NB-1:0][31:0]   b_fsr;
		logic [NB-1:0][31:0]   b_far;
		logic [NB-1:0][31:0]   b_par;
		logic [31:0]           rdata;
		logic                  abort;
		logic                  fwd;
		logic                  s_cirq;
		logic                  s_girq;
		logic                  ns_cirq;
		logic                  ns_girq;
	} cfr_state_t;

	cfr_state_t state_ff;
	cfr_state_t nxt_state;

	////////////////////////////////////////////////////////////////////
	// configuration access decode

	logic            acc_v;
	logic            in_bank;
	logic            bank_ok;
	logic            sec_reg;
	logic            impl;
	logic            sec_viol;
	logic            caf;
	logic            hit;
	logic            to_sec;
	logic [2:0]      bidx;
	logic [7:0]      boff;
	logic [C1_W-1:0] c1_mask;

	assign acc_v   = cfg_req_i.wr | cfg_req_i.rd;
	assign in_bank = cfg_req_i.addr[BANK_BIT];
	assign bidx    = cfg_req_i.addr[BANK_MSB:BANK_LSB];
	assign boff    = cfg_req_i.addr[BANK_LSB-1:0];
	// secure banks stay invisible to ns software
	assign bank_ok = in_bank && (32'(bidx) < NB) &&
		(cfg_req_i.secure || !BANK_SECURE[bidx]);

	always_comb begin
		sec_reg = 1'b0;
		impl    = 1'b1;
		case (cfg_req_i.addr)
			OFF_SCR0, OFF_SCR1, OFF_SGFSR, OFF_SSYN0, OFF_SGFAR: begin
				sec_reg = 1'b1;
			end
			OFF_NSCR0, OFF_NSGFSR, OFF_NSGFAR, OFF_GPAR: begin
				sec_reg = 1'b0;
			end
			default: begin
				impl = 1'b0;
			end
		endcase
	end

	assign sec_viol = !cfg_req_i.secure &&
		(sec_reg || state_ff.s_ctl1[C1_GLOBAL_SPACE_SECURE_ONLY]);
	// bank space is excluded: holes and foreign banks read zero instead
	assign caf = acc_v && !in_bank && (
		(sec_viol && NS_CAF) ||
		(!impl && UNIMPL_CAF) ||
		(!cfg_req_i.priv && PRIV_CAF));
	assign hit = acc_v && !caf && !in_bank && impl && !sec_viol &&
		cfg_req_i.priv;
	assign to_sec = TWO_SEC && (cfg_req_i.secure ||
		(sec_viol && !state_ff.s_ctl1[C1_NS_CFG_FAULT_REDIRECT]));
	// the ext redirect bit only exists without upstream error transport
	assign c1_mask = {TWO_SEC && !UPSTREAM_ERR, 2'b11};

	////////////////////////////////////////////////////////////////////
	// external fault decode

	logic [2:0] tb;
	logic       glob;
	logic       gsec;

	assign tb   = ext_fault_i.nested ? ext_fault_i.s2_bank
		: ext_fault_i.bank;
	assign glob = ext_fault_i.bypass ||
		(!ext_fault_i.sync && ASYNC_GLOBAL) ||
		(32'(tb) >= NB);
	assign gsec = TWO_SEC && (state_ff.s_ctl1[C1_EXT_FAULT_SECURE_REDIRECT] ||
		(ext_fault_i.sec_known && ext_fault_i.secure));

	function automatic logic [31:0] rec_fsr(
		input logic [31:0] cur,
		input logic        busy,
		input int unsigned bitn
	);
		logic [31:0] v;
		v = cur;
		if (busy) begin
			v[FS_MULTI] = 1'b1;
		end else begin
			v[bitn] = 1'b1;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic s_busy;
		logic ns_busy;
		s_busy  = 1'b0;
		ns_busy = 1'b0;
		nxt_state       = state_ff;
		nxt_state.rdata = RST_W32;
		nxt_state.abort = 1'b0;
		nxt_state.fwd   = 1'b0;

		// software writes; status clears are applied before any set
		if (hit && cfg_req_i.wr) begin
			case (cfg_req_i.addr)
				OFF_SCR0: begin
					nxt_state.s_ctl0 = cfg_req_i.wdata[C0_W-1:0];
				end
				OFF_NSCR0: begin
					nxt_state.ns_ctl0 = cfg_req_i.wdata[C0_W-1:0];
				end
				OFF_SCR1: begin
					nxt_state.s_ctl1 = cfg_req_i.wdata[C1_W-1:0] & c1_mask;
				end
				OFF_SGFSR: begin
					nxt_state.s_fsr = state_ff.s_fsr &
						~(cfg_req_i.wdata & FS_MASK);
				end
				OFF_NSGFSR: begin
					nxt_state.ns_fsr = state_ff.ns_fsr &
						~(cfg_req_i.wdata & FS_MASK);
				end
				default: begin
				end
			endcase
		end
		if (hit && cfg_req_i.rd) begin
			case (cfg_req_i.addr)
				OFF_SCR0:   nxt_state.rdata = 32'(state_ff.s_ctl0);
				OFF_NSCR0:  nxt_state.rdata = 32'(state_ff.ns_ctl0);
				OFF_SCR1:   nxt_state.rdata = 32'(state_ff.s_ctl1);
				OFF_SGFSR:  nxt_state.rdata = state_ff.s_fsr;
				OFF_NSGFSR: nxt_state.rdata = state_ff.ns_fsr;
				OFF_SSYN0:  nxt_state.rdata = 32'(state_ff.s_syn_ns);
				OFF_SGFAR:  nxt_state.rdata = state_ff.s_far;
				OFF_NSGFAR: nxt_state.rdata = state_ff.ns_far;
				OFF_GPAR:   nxt_state.rdata = state_ff.gpar;
				default:    nxt_state.rdata = RST_W32;
			endcase
		end

		// bank space: holes and foreign banks read zero
		if (bank_ok && cfg_req_i.wr && boff == BOFF_FSR) begin
			nxt_state.b_fsr[bidx] = state_ff.b_fsr[bidx] &
				~(cfg_req_i.wdata & FS_MASK);
		end
		if (bank_ok && cfg_req_i.rd) begin
			case (boff)
				BOFF_FSR: nxt_state.rdata = state_ff.b_fsr[bidx];
				BOFF_FAR: nxt_state.rdata = state_ff.b_far[bidx];
				BOFF_PAR: nxt_state.rdata = state_ff.b_par[bidx];
				default:  nxt_state.rdata = RST_W32;
			endcase
		end

		// configuration access faults
		if (caf) begin
			if (to_sec) begin
				s_busy = |state_ff.s_fsr;
				nxt_state.s_fsr = rec_fsr(nxt_state.s_fsr, s_busy,
					FS_CAF);
				if (!s_busy) begin
					nxt_state.s_far = 32'(cfg_req_i.addr);
					nxt_state.s_syn_ns = !cfg_req_i.secure &&
						!UPSTREAM_ERR;
				end
				nxt_state.abort = state_ff.s_ctl0[C0_REP];
			end else begin
				// secure syndrome is deliberately left alone here
				ns_busy = |state_ff.ns_fsr;
				nxt_state.ns_fsr = rec_fsr(nxt_state.ns_fsr, ns_busy,
					FS_CAF);
				if (!ns_busy) begin
					nxt_state.ns_far = 32'(cfg_req_i.addr);
				end
				nxt_state.abort = state_ff.ns_ctl0[C0_REP];
			end
		end

		// external faults; a same-cycle config fault counts as busy
		s_busy  = (|state_ff.s_fsr) || (|nxt_state.s_fsr);
		ns_busy = (|state_ff.ns_fsr) || (|nxt_state.ns_fsr);
		if (ext_valid_i) begin
			if (ext_fault_i.src == CFR_DOWNSTREAM && UPSTREAM_ERR) begin
				nxt_state.fwd = 1'b1;
			end else if (ext_fault_i.src == CFR_WALK_ATOS) begin
				if (ext_fault_i.s2_for_s1_op &&
					32'(ext_fault_i.s2_bank) < NB) begin
					nxt_state.b_fsr[ext_fault_i.s2_bank][FS_EF] =
						1'b1;
					if (ext_fault_i.sync) begin
						nxt_state.b_far[ext_fault_i.s2_bank] =
							ext_fault_i.addr;
					end
					if (32'(ext_fault_i.bank) < NB) begin
						nxt_state.b_par[ext_fault_i.bank] =
							PAR_TRANSLATION_OP_TERMINATED;
					end
				end else if (ext_fault_i.bypass ||
					32'(ext_fault_i.bank) >= NB) begin
					nxt_state.gpar = PAR_EXT;
				end else begin
					nxt_state.b_par[ext_fault_i.bank] = PAR_EXT;
				end
			end else if (glob && UPSTREAM_ERR) begin
				// the global flag does not exist on such a bus
				nxt_state.fwd = 1'b1;
			end else if (glob && gsec) begin
				nxt_state.s_fsr = rec_fsr(nxt_state.s_fsr, s_busy,
					FS_EF);
				if (!s_busy && ext_fault_i.sync) begin
					nxt_state.s_far = ext_fault_i.addr;
				end
			end else if (glob) begin
				nxt_state.ns_fsr = rec_fsr(nxt_state.ns_fsr, ns_busy,
					FS_EF);
				if (!ns_busy && ext_fault_i.sync) begin
					nxt_state.ns_far = ext_fault_i.addr;
				end
			end else begin
				nxt_state.b_fsr[tb][FS_EF] = 1'b1;
				if (ext_fault_i.sync) begin
					nxt_state.b_far[tb] = ext_fault_i.addr;
				end
			end
		end

		// repeat flag from a config fault drives the global line
		nxt_state.s_cirq = nxt_state.s_fsr[FS_CAF] &&
			nxt_state.s_ctl0[C0_IRQ];
		nxt_state.s_girq = (|(nxt_state.s_fsr & FS_GLB)) &&
			nxt_state.s_ctl0[C0_GIRQ];
		nxt_state.ns_cirq = nxt_state.ns_fsr[FS_CAF] &&
			nxt_state.ns_ctl0[C0_IRQ];
		nxt_state.ns_girq = (|(nxt_state.ns_fsr & FS_GLB)) &&
			nxt_state.ns_ctl0[C0_GIRQ];
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign reg_rdata_o                  = state_ff.rdata;
	assign reg_abort_o                  = state_ff.abort;
	assign client_abort_o               = state_ff.fwd;
	assign secure_cfg_fault_interrupt_o = state_ff.s_cirq;
	assign secure_global_interrupt_o    = state_ff.s_girq;
	assign ns_cfg_fault_interrupt_o     = state_ff.ns_cirq;
	assign ns_global_interrupt_o        = state_ff.ns_girq;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_bank_no_abort: assert property (
		acc_v && in_bank |=> !reg_abort_o &&
			(reg_rdata_o == RST_W32 || $past(bank_ok)))
		else $error("bank access aborted or read nonzero");

	chk_ns_sec_caf: assert property (
		caf && sec_viol && !state_ff.s_ctl1[C1_NS_CFG_FAULT_REDIRECT] &&
		state_ff.s_fsr == RST_W32 && TWO_SEC
		|=> state_ff.s_fsr[FS_CAF] && state_ff.s_syn_ns == !UPSTREAM_ERR)
		else $error("ns violation not in secure status");

	chk_cfg_irq: assert property (
		state_ff.s_fsr[FS_CAF] && state_ff.s_ctl0[C0_IRQ] && !hit
		|=> secure_cfg_fault_interrupt_o)
		else $error("secure cfg fault irq missing");

	chk_cfg_abort: assert property (
		caf && to_sec |=> reg_abort_o == $past(state_ff.s_ctl0[C0_REP]))
		else $error("secure cfg fault abort wrong");

	chk_redirect_ns: assert property (
		caf && sec_viol && state_ff.s_ctl1[C1_NS_CFG_FAULT_REDIRECT] &&
		state_ff.ns_fsr == RST_W32
		|=> state_ff.ns_fsr[FS_CAF] && $stable(state_ff.s_syn_ns))
		else $error("redirected fault misrouted");

	chk_multi_only: assert property (
		caf && to_sec && state_ff.s_fsr != RST_W32
		|=> state_ff.s_fsr[FS_MULTI] && $stable(state_ff.s_far) &&
			$stable(state_ff.s_syn_ns))
		else $error("busy status overwritten");

	chk_fwd_client: assert property (
		ext_valid_i && ext_fault_i.src == CFR_DOWNSTREAM
		|=> client_abort_o == UPSTREAM_ERR)
		else $error("downstream abort forwarding wrong");

	chk_bank_sync: assert property (
		ext_valid_i && ext_fault_i.src == CFR_WALK_CLIENT && !glob &&
		ext_fault_i.sync
		|=> state_ff.b_far[$past(tb)] == $past(ext_fault_i.addr))
		else $error("sync bank fault address not loaded");

	chk_async_far: assert property (
		ext_valid_i && glob && !ext_fault_i.sync && !caf &&
		ext_fault_i.src != CFR_WALK_ATOS && !UPSTREAM_ERR
		|=> $stable(state_ff.s_far) && $stable(state_ff.ns_far))
		else $error("async fault touched fault address");
endmodule
`default_nettype wire

//--- tb/cfr_dn_model.sv
`timescale 1ns/1ps
`default_nettype none
// downstream memory side: presents one abort per call
module cfr_dn_model (
	input  wire logic                core_clk_i,
	output var logic                 ext_valid_o,
	output var cfr_pkg::cfr_ext_fault_t ext_fault_o
);
	import cfr_pkg::*;
	initial begin
		ext_valid_o = 1'b0;
		ext_fault_o = '0;
	end
	task automatic send(input cfr_ext_fault_t f);
		begin
			@(posedge core_clk_i);
			ext_valid_o <= 1'b1;
			ext_fault_o <= f;
			@(posedge core_clk_i);
			ext_valid_o <= 1'b0;
			// released lines show garbage, never the last value
			ext_fault_o <= cfr_ext_fault_t'(~f);
		end
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cfr_pkg::*;
	logic           core_clk_i;
	logic           rst_b_i;
	cfr_cfg_req_t   req;
	logic           ext_valid;
	cfr_ext_fault_t ext_f;
	logic [31:0]    rdata;
	logic           abort;
	logic           scfg;
	logic           sglb;
	logic           nscfg;
	logic           nsglb;
	logic           cabort;
	logic [31:0]    fwd_rdata;
	logic           fwd_abort;
	int             fail_count;
	int             compares;
	int             cyc;

	cfr_dn_model dn_u (
		.core_clk_i  (core_clk_i),
		.ext_valid_o (ext_valid),
		.ext_fault_o (ext_f)
	);
	cfr_core dut_u (
		.core_clk_i                   (core_clk_i),
		.rst_b_i                      (rst_b_i),
		.cfg_req_i                    (req),
		.ext_valid_i                  (ext_valid),
		.ext_fault_i                  (ext_f),
		.reg_rdata_o                  (rdata),
		.reg_abort_o                  (abort),
		.client_abort_o               (cabort),
		.secure_cfg_fault_interrupt_o (scfg),
		.secure_global_interrupt_o    (sglb),
		.ns_cfg_fault_interrupt_o     (nscfg),
		.ns_global_interrupt_o        (nsglb)
	);
	// second copy on an error-capable bus: downstream and global client walk faults go upstream
	cfr_core #(
		.UPSTREAM_ERR (1'b1)
	) dut_fwd_u (
		.core_clk_i                   (core_clk_i),
		.rst_b_i                      (rst_b_i),
		.cfg_req_i                    (req),
		.ext_valid_i                  (ext_valid),
		.ext_fault_i                  (ext_f),
		.reg_rdata_o                  (fwd_rdata),
		.reg_abort_o                  (),
		.client_abort_o               (fwd_abort),
		.secure_cfg_fault_interrupt_o (),
		.secure_global_interrupt_o    (),
		.ns_cfg_fault_interrupt_o     (),
		.ns_global_interrupt_o        ()
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		// whole run is under two hundred cycles
		if (cyc == 5000) begin
			fail_count = fail_count + 1;
			final_report();
		end
	end

	task final_report();
		begin
			if (fail_count == 0 && compares > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask

	task rd(input logic [11:0] a, input logic s, input logic p,
		input logic [31:0] e, input logic ab);
		begin
			@(posedge core_clk_i);
			req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1,
				secure: s, priv: p};
			@(posedge core_clk_i);
			req.rd <= 1'b0;
			#1;
			chk(rdata, e);
			chk({31'h0, abort}, {31'h0, ab});
		end
	endtask

	task wr(input logic [11:0] a, input logic s, input logic [31:0] d);
		begin
			@(posedge core_clk_i);
			req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0,
				secure: s, priv: 1'b1};
			@(posedge core_clk_i);
			req.wr <= 1'b0;
		end
	endtask

	task irq(input logic seen, input logic exp);
		begin
			@(posedge core_clk_i);
			#1;
			chk({31'h0, seen}, {31'h0, exp});
		end
	endtask

	function automatic logic [11:0] ba(input logic [2:0] n,
		input logic [7:0] off);
		ba = {1'b1, n, off};
	endfunction

	task ext(input cfr_src_t src, input logic sy, input logic by,
		input logic ne, input logic so, input logic [2:0] b,
		input logic [2:0] b2, input logic kn, input logic se,
		input logic [31:0] ad);
		dn_u.send('{src, sy, by, ne, so, b, b2, kn, se, ad});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		fail_count = 0;
		compares = 0;
		cyc = 0;
		req = '0;
		rst_b_i = 1'b0;
		repeat (8) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		rd(OFF_SCR0, 1'b1, 1'b1, RST_W32, 1'b0);
		rd(OFF_SGFSR, 1'b1, 1'b1, RST_W32, 1'b0);
		rd(OFF_NSGFSR, 1'b0, 1'b1, RST_W32, 1'b0);
		wr(OFF_SCR0, 1'b1, 32'hFFFFFFFF);
		wr(OFF_NSCR0, 1'b0, 32'h00000007);
		rd(OFF_SCR0, 1'b1, 1'b1, 32'h00000007, 1'b0);
		rd(OFF_SCR0, 1'b1, 1'b0, 32'h00000000, 1'b0);
		// ns access to secure registers
		rd(OFF_SCR1, 1'b0, 1'b1, 32'h00000000, 1'b1);
		irq(scfg, 1'b1);
		rd(OFF_SGFSR, 1'b1, 1'b1, 32'h00000002, 1'b0);
		rd(OFF_SSYN0, 1'b1, 1'b1, 32'h00000001, 1'b0);
		chk(fwd_rdata, 32'h00000000);
		rd(OFF_SGFAR, 1'b1, 1'b1, 32'h00000004, 1'b0);
		rd(OFF_SCR0, 1'b0, 1'b1, 32'h00000000, 1'b1);
		rd(OFF_SGFSR, 1'b1, 1'b1, 32'h80000002, 1'b0);
		rd(OFF_SGFAR, 1'b1, 1'b1, 32'h00000004, 1'b0);
		irq(sglb, 1'b1);
		wr(OFF_SGFSR, 1'b1, 32'hFFFFFFFF);
		rd(OFF_SGFSR, 1'b1, 1'b1, 32'h00000000, 1'b0);
		// redirect to the non-secure group
		wr(OFF_SCR1, 1'b1, 32'h00000001);
		rd(OFF_SCR0, 1'b0, 1'b1, 32'h00000000, 1'b1);
		rd(OFF_SGFSR, 1'b1, 1'b1, 32'h00000000, 1'b0);
		rd(OFF_NSGFSR, 1'b0, 1'b1, 32'h00000002, 1'b0);
		irq(nscfg, 1'b1);
		rd(OFF_SSYN0, 1'b1, 1'b1, 32'h00000001, 1'b0);
		rd(12'h8FC, 1'b0, 1'b1, 32'h00000000, 1'b0);
		rd(12'hF00, 1'b0, 1'b1, 32'h00000000, 1'b0);
		rd(12'h0F0, 1'b1, 1'b1, 32'h00000000, 1'b1);
		wr(OFF_NSGFSR, 1'b0, 32'hFFFFFFFF);
		wr(OFF_SGFSR, 1'b1, 32'hFFFFFFFF);
		// global space secure only
		wr(OFF_SCR1, 1'b1, 32'h00000002);
		rd(OFF_NSCR0, 1'b0, 1'b1, 32'h00000000, 1'b1);
		rd(OFF_SGFSR, 1'b1, 1'b1, 32'h00000002, 1'b0);
		wr(OFF_SGFSR, 1'b1, 32'hFFFFFFFF);
		// external faults
		wr(OFF_SCR1, 1'b1, 32'h00000004);
		rd(OFF_SCR1, 1'b1, 1'b1, 32'h00000004, 1'b0);
		chk(fwd_rdata, 32'h00000000);
		ext(CFR_WALK_CLIENT, 1, 0, 0, 0, 3'd1, 3'd0, 0, 0, 32'h00001234);
		rd(ba(3'd1, BOFF_FSR), 1'b1, 1'b1, 32'h00000001, 1'b0);
		rd(ba(3'd1, BOFF_FAR), 1'b1, 1'b1, 32'h00001234, 1'b0);
		ext(CFR_DOWNSTREAM, 1, 0, 1, 0, 3'd0, 3'd2, 0, 0, 32'h00000040);
		#1;
		chk({31'h0, fwd_abort}, 32'h00000001);
		chk({31'h0, cabort}, 32'h00000000);
		rd(ba(3'd2, BOFF_FSR), 1'b1, 1'b1, 32'h00000001, 1'b0);
		rd(ba(3'd0, BOFF_FSR), 1'b1, 1'b1, 32'h00000000, 1'b0);
		ext(CFR_WALK_ATOS, 1, 0, 0, 0, 3'd3, 3'd0, 0, 0, 32'h00000080);
		rd(ba(3'd3, BOFF_PAR), 1'b1, 1'b1, PAR_EXT, 1'b0);
		rd(ba(3'd3, BOFF_FSR), 1'b1, 1'b1, 32'h00000000, 1'b0);
		ext(CFR_WALK_ATOS, 1, 0, 0, 1, 3'd0, 3'd3, 0, 0, 32'h000000C0);
		rd(ba(3'd0, BOFF_PAR), 1'b1, 1'b1, PAR_TRANSLATION_OP_TERMINATED, 1'b0);
		rd(ba(3'd3, BOFF_FSR), 1'b1, 1'b1, 32'h00000001, 1'b0);
		ext(CFR_DOWNSTREAM, 0, 0, 0, 0, 3'd1, 3'd0, 1, 0, 32'h00000100);
		rd(OFF_SGFSR, 1'b1, 1'b1, 32'h00000001, 1'b0);
		rd(OFF_SGFAR, 1'b1, 1'b1, 32'h00000008, 1'b0);
		irq(sglb, 1'b1);
		wr(OFF_SGFSR, 1'b1, 32'hFFFFFFFF);
		wr(OFF_SCR1, 1'b1, 32'h00000000);
		ext(CFR_DOWNSTREAM, 1, 1, 0, 0, 3'd0, 3'd0, 1, 1, 32'h00000ABC);
		rd(OFF_SGFSR, 1'b1, 1'b1, 32'h00000001, 1'b0);
		chk(fwd_rdata, 32'h00000000);
		rd(OFF_SGFAR, 1'b1, 1'b1, 32'h00000ABC, 1'b0);
		ext(CFR_DOWNSTREAM, 0, 0, 0, 0, 3'd2, 3'd0, 0, 1, 32'h00000200);
		rd(OFF_NSGFSR, 1'b0, 1'b1, 32'h00000001, 1'b0);
		irq(nsglb, 1'b1);
		rd(OFF_SGFSR, 1'b1, 1'b1, 32'h00000001, 1'b0);
		// bank beyond the implemented count falls back to global
		ext(CFR_WALK_CLIENT, 1, 0, 0, 0, 3'd5, 3'd0, 0, 0, 32'h00000300);
		rd(OFF_NSGFSR, 1'b0, 1'b1, 32'h80000001, 1'b0);
		rd(OFF_NSGFAR, 1'b0, 1'b1, 32'h00000000, 1'b0);
		// reset in mid-run wipes status and interrupts
		@(posedge core_clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		rd(OFF_SGFSR, 1'b1, 1'b1, RST_W32, 1'b0);
		rd(OFF_NSGFSR, 1'b0, 1'b1, RST_W32, 1'b0);
		irq(sglb, 1'b0);
		irq(nsglb, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
